// [ahb_retract_params.svh]
`ifndef AHB_RETRACT_PARAMS_SVH
`define AHB_RETRACT_PARAMS_SVH

// ****************************************
// Bus field widths
// ****************************************
`define ADDR_W        32
`define DATA_W        64
`define RESP_W        3
`define TRANS_W       2
`define SIZE_W        3

// ****************************************
// Transfer type, response and burst encodings
// ****************************************
`define TRANS_IDLE    2'h0
`define TRANS_NONSEQ  2'h2
`define TRANS_SEQ     2'h3
`define RESP_OKAY     3'h0
`define RESP_ERROR    3'h1
`define BURST_SINGLE  3'h0
`define BURST_INCR    3'h1

// ****************************************
// Reset values
// ****************************************
`define RST_DATA      64'h0000_0000_0000_0000

`endif

// [ahb_retract_pkg.sv]
`include "ahb_retract_params.svh"

package ahb_retract_pkg;

	// Request as the core presents it to the bus interface unit
	typedef struct packed {
		logic [`ADDR_W-1:0] addr;
		logic               write;
		logic [`SIZE_W-1:0] size;
		logic               burst;
		logic               seq;
		logic               cont;
		logic [`DATA_W-1:0] wdata;
	} req_t;

	// Address phase as driven onto the bus
	typedef struct packed {
		logic [`TRANS_W-1:0] trans;
		logic [`ADDR_W-1:0]  addr;
		logic                write;
		logic [`SIZE_W-1:0]  size;
		logic [2:0]          burst;
	} aphase_t;

	// Answer to the core for a finished data phase
	typedef struct packed {
		logic               valid;
		logic               err;
		logic [`DATA_W-1:0] rdata;
	} rsp_t;

endpackage

// [ahb_resp_decode.sv]
`include "ahb_retract_params.svh"

module ahb_resp_decode (
	input  wire logic               dph_valid_i,
	input  wire logic               hready_i,
	input  wire logic [`RESP_W-1:0] hresp_i,
	output logic                    done_o,
	output logic                    ok_done_o,
	output logic                    err_first_o,
	output logic                    err_second_o
);

	wire is_err;
	wire is_ok;

	assign is_err = (hresp_i == `RESP_ERROR);
	assign is_ok  = (hresp_i == `RESP_OKAY);

	assign done_o       = dph_valid_i & hready_i;
	assign ok_done_o    = dph_valid_i & hready_i & is_ok;
	assign err_first_o  = dph_valid_i & ~hready_i & is_err;
	assign err_second_o = dph_valid_i & hready_i & is_err;

endmodule

// [bus_interface_unit.sv]
`include "ahb_retract_params.svh"

module bus_interface_unit
	import ahb_retract_pkg::*;
(
	input  wire logic                          mclk_i,
	input  wire logic                          resetn_i,
	input  wire logic                          req_valid_i,
	input  wire ahb_retract_pkg::req_t         req_i,
	output logic                               req_taken_o,
	output logic                               req_abort_o,
	output ahb_retract_pkg::rsp_t              rsp_o,
	output ahb_retract_pkg::aphase_t           aphase_o,
	output logic [`DATA_W-1:0]                 hwdata_o,
	input  wire logic                          hready_i,
	input  wire logic [`RESP_W-1:0]            hresp_i,
	input  wire logic [`DATA_W-1:0]            hrdata_i
);

	import ahb_retract_pkg::*;

	function automatic aphase_t to_aphase(input req_t r, input logic v);
		aphase_t a;
		a.trans = !v ? `TRANS_IDLE : (r.seq ? `TRANS_SEQ : `TRANS_NONSEQ);
		a.addr  = r.addr;
		a.write = r.write;
		a.size  = r.size;
		a.burst = r.burst ? `BURST_INCR : `BURST_SINGLE;
		return a;
	endfunction

	// ****************************************
	// State
	// ****************************************
	logic               dph_valid_q;
	logic               dph_write_q;
	logic               hold_q;
	req_t               held_q;
	logic [`DATA_W-1:0] hwdata_q;
	rsp_t               rsp_q;

	wire done;
	wire ok_done;
	wire err_first;
	wire err_second;

	ahb_resp_decode u_resp (
		.dph_valid_i  (dph_valid_q),
		.hready_i     (hready_i),
		.hresp_i      (hresp_i),
		.done_o       (done),
		.ok_done_o    (ok_done),
		.err_first_o  (err_first),
		.err_second_o (err_second)
	);

	// ****************************************
	// Address phase selection
	// ****************************************
	// A write that has been shown stays frozen on the bus until taken or dropped in a second error cycle; the core may
	// still swap its reads freely, which is the whole point of retraction.
	wire   use_held;
	wire   drop_cont;
	wire   show_valid;
	wire   bus_free;
	wire   taken;
	req_t  shown;

	assign use_held   = hold_q & ~err_second;
	assign shown      = use_held ? held_q : req_i;
	assign drop_cont  = err_second & req_valid_i & req_i.cont;
	assign show_valid = use_held | (req_valid_i & ~drop_cont);
	assign bus_free   = ~dph_valid_q | hready_i;
	assign taken      = show_valid & bus_free;

	assign aphase_o    = to_aphase(shown, show_valid);
	assign req_taken_o = taken;
	assign req_abort_o = drop_cont | (err_second & hold_q);
	assign hwdata_o    = hwdata_q;
	assign rsp_o       = rsp_q;

	// ****************************************
	// Write hold
	// ****************************************
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			hold_q <= 1'b0;
			held_q <= '0;
		end else if (taken || err_second) begin
			hold_q <= 1'b0;
		end else if (!hold_q && req_valid_i && req_i.write) begin
			hold_q <= 1'b1;
			held_q <= req_i;
		end
	end

	// ****************************************
	// Data phase
	// ****************************************
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			dph_valid_q <= 1'b0;
			dph_write_q <= 1'b0;
			hwdata_q    <= `RST_DATA;
		end else begin
			if (bus_free) begin
				dph_valid_q <= taken;
				dph_write_q <= taken & shown.write;
			end
			if (taken && shown.write) begin
				hwdata_q <= shown.wdata;
			end
		end
	end

	// ****************************************
	// Answer to the core
	// ****************************************
	// Error data is forced to zero so a stale bus value can never leak.
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rsp_q <= '0;
		end else begin
			rsp_q.valid <= done;
			rsp_q.err   <= err_second;
			rsp_q.rdata <= (ok_done && !dph_write_q) ? hrdata_i : `RST_DATA;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	a_idle_take_now: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(!dph_valid_q && show_valid) |-> taken)
		else $error("request on idle bus not taken");
	a_busy_no_take: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(dph_valid_q && !hready_i) |-> !taken)
		else $error("request taken while access outstanding");
	a_wdata_next: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(taken && shown.write) |=> (hwdata_o == $past(shown.wdata)) && dph_write_q)
		else $error("write data not driven after address taken");
	a_err_no_data: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		err_second |=> rsp_o.valid && rsp_o.err && (rsp_o.rdata == `RST_DATA))
		else $error("error response passed data");
	a_write_stable: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(aphase_o.trans != `TRANS_IDLE && aphase_o.write && !taken && !err_second)
		|=> !err_second |-> $stable(aphase_o))
		else $error("pending write changed before taken");
	a_cont_dropped: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(err_second && req_valid_i && req_i.cont && !hold_q)
		|-> (aphase_o.trans == `TRANS_IDLE) && req_abort_o)
		else $error("continuation not dropped on error");
	a_keep_after_err: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(err_second && req_valid_i && !req_i.cont) |-> taken ##1 dph_valid_q)
		else $error("kept request not taken in second error cycle");
	a_err_two_cycle: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		err_first ##1 err_second |-> rsp_o.valid == 1'b0)
		else $error("answer given in first error cycle");
	a_ok_read_data: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		(ok_done && !dph_write_q) |=> (rsp_o.rdata == $past(hrdata_i)) && !rsp_o.err)
		else $error("read data not returned on okay");

	c_error_retract: cover property (@(posedge mclk_i) err_first ##1 err_second && req_abort_o);
	c_error_keep: cover property (@(posedge mclk_i) err_second && taken);
	c_read_swap: cover property (@(posedge mclk_i)
		(dph_valid_q && !hready_i && show_valid && !aphase_o.write) ##1 taken);
	c_burst_seq: cover property (@(posedge mclk_i) taken && aphase_o.trans == `TRANS_SEQ);

endmodule

// [ahb_slave_model.sv]
`include "ahb_retract_params.svh"

// ****************************************
// Slave model with wait states and two-cycle error replies
// ****************************************
module ahb_slave_model
	import ahb_retract_pkg::*;
(
	input  wire logic                     mclk_i,
	input  wire logic                     resetn_i,
	input  wire ahb_retract_pkg::aphase_t aphase_i,
	input  wire logic [3:0]               wait_i,
	input  wire logic                     err_i,
	output logic                          hready_o,
	output logic [`RESP_W-1:0]            hresp_o,
	output logic [`DATA_W-1:0]            hrdata_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic               busy_q;
	logic               err_q;
	logic               second_q;
	logic               take;
	logic               ok_end;
	logic [3:0]         cnt_q;
	logic [`ADDR_W-1:0] addr_q;
	logic [`ADDR_W-1:0] cyc_q;
	// Any NONSEQ or SEQ transfer shown while ready is high is accepted as it stands; IDLE is not taken
	assign take     = hready_o && aphase_i.trans[1];
	assign ok_end   = busy_q && !err_q && (cnt_q == 4'h0);
	assign hready_o = !busy_q || (err_q ? second_q : cnt_q == 4'h0);
	assign hresp_o  = (busy_q && err_q) ? `RESP_ERROR : `RESP_OKAY;
	// Data lines toggle outside a good completion so stale data never looks valid
	assign hrdata_o = ok_end ? {~addr_q, addr_q} : {cyc_q, ~cyc_q};
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			busy_q   <= 1'b0;
			err_q    <= 1'b0;
			second_q <= 1'b0;
			cnt_q    <= 4'h0;
			addr_q   <= 32'h0;
			cyc_q    <= 32'h0;
		end else begin
			cyc_q <= cyc_q + 32'h1;
			if (hready_o) begin
				busy_q   <= take;
				err_q    <= err_i;
				second_q <= 1'b0;
				cnt_q    <= wait_i;
				addr_q   <= aphase_i.addr;
			end else if (err_q) begin
				second_q <= 1'b1;
			end else begin
				cnt_q <= cnt_q - 4'h1;
			end
		end
	end
endmodule

// [tb.sv]
`include "ahb_retract_params.svh"

module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import ahb_retract_pkg::*;
	typedef struct packed {
		req_t        r;
		logic [3:0]  w;
		logic [63:0] d;
	} row_t;
	logic               mclk_i = 1'b0;
	logic               resetn_i = 1'b0;
	logic               req_valid_i = 1'b0;
	req_t               req_i = '0;
	logic               req_taken_o, req_abort_o, hready;
	logic               err_n = 1'b0;
	logic [3:0]         wait_n = 4'h0;
	rsp_t               rsp_o;
	aphase_t            aphase_o;
	logic [`DATA_W-1:0] hwdata_o, hrdata;
	logic [`RESP_W-1:0] hresp;
	int                 num_errors = 0;
	int                 n_compared = 0;
	int                 cycles = 0;
	row_t               rows [4];

	always #2 mclk_i = ~mclk_i;

	bus_interface_unit u_dut (.mclk_i(mclk_i), .resetn_i(resetn_i), .req_valid_i(req_valid_i),
		.req_i(req_i), .req_taken_o(req_taken_o), .req_abort_o(req_abort_o), .rsp_o(rsp_o),
		.aphase_o(aphase_o), .hwdata_o(hwdata_o), .hready_i(hready), .hresp_i(hresp),
		.hrdata_i(hrdata));
	ahb_slave_model u_slave (.mclk_i(mclk_i), .resetn_i(resetn_i), .aphase_i(aphase_o),
		.wait_i(wait_n), .err_i(err_n), .hready_o(hready), .hresp_o(hresp), .hrdata_o(hrdata));

	function automatic req_t mk(input logic [31:0] a, input logic wr, bu, co);
		mk = '{addr: a, write: wr, size: 3'h3, burst: bu, seq: co, cont: co, wdata: {a, ~a}};
	endfunction
	function automatic logic [63:0] rd(input req_t r);
		rd = r.write ? 64'h0 : {~r.addr, r.addr};
	endfunction
	task automatic check(input logic [63:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		$display("Compared %0d, errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic issue(input req_t r, input logic [3:0] w, input logic e);
		@(posedge mclk_i);
		req_valid_i <= 1'b1;
		req_i <= r;
		wait_n <= w;
		err_n <= e;
		@(negedge mclk_i);
		check(64'(req_taken_o), 64'h1);
		check(64'({aphase_o.write, aphase_o.size, aphase_o.burst}),
			64'({r.write, r.size, r.burst ? `BURST_INCR : `BURST_SINGLE}));
	endtask
	task automatic wait_rsp(input logic e, input logic [63:0] d);
		int k;
		k = 0;
		do begin
			@(negedge mclk_i);
			k++;
		end while (rsp_o.valid !== 1'b1 && k < 20);
		check(64'(rsp_o.valid), 64'h1);
		check(64'(rsp_o.err), 64'(e));
		check(rsp_o.rdata, d);
	endtask
	task automatic err_case(input req_t a, b, input logic keep);
		issue(a, 4'h0, 1'b1);
		@(posedge mclk_i);
		req_i <= b;
		err_n <= 1'b0;
		@(negedge mclk_i);
		check(64'(req_taken_o), 64'h0);
		@(negedge mclk_i);
		check(64'(req_taken_o), 64'(keep));
		check(64'(req_abort_o), 64'(!keep));
		check(64'(aphase_o.trans), keep ? 64'(`TRANS_NONSEQ) : 64'(`TRANS_IDLE));
		@(posedge mclk_i);
		req_valid_i <= 1'b0;
		wait_rsp(1'b1, 64'h0);
		if (keep) wait_rsp(1'b0, rd(b));
	endtask
	task automatic retract(input req_t b, c);
		issue(mk(32'h400, 1'b0, 1'b1, 1'b0), 4'h2, 1'b0);
		@(posedge mclk_i);
		req_i <= b;
		@(posedge mclk_i);
		req_i <= c;
		@(negedge mclk_i);
		check(64'(req_taken_o), 64'h0);
		check(64'(aphase_o.addr), 64'(b.write ? b.addr : c.addr));
		@(negedge mclk_i);
		check(64'(req_taken_o), 64'h1);
		@(posedge mclk_i);
		req_valid_i <= 1'b0;
		wait_rsp(1'b0, rd(mk(32'h400, 1'b0, 1'b1, 1'b0)));
		wait_rsp(1'b0, b.write ? 64'h0 : rd(c));
	endtask

	always @(posedge mclk_i) begin
		cycles++;
		if (cycles == 2000) begin
			num_errors++;
			print_verdict();
		end
	end

	initial begin
		rows = '{'{mk(32'h100, 1'b0, 1'b0, 1'b0), 4'h0, 64'hffff_feff_0000_0100},
			'{mk(32'h108, 1'b1, 1'b0, 1'b0), 4'h0, 64'h0},
			'{mk(32'h110, 1'b0, 1'b0, 1'b0), 4'h3, 64'hffff_feef_0000_0110},
			'{mk(32'h118, 1'b1, 1'b0, 1'b0), 4'h1, 64'h0}};
		repeat (20) @(posedge mclk_i);
		resetn_i <= 1'b1;
		foreach (rows[i]) begin
			issue(rows[i].r, rows[i].w, 1'b0);
			@(posedge mclk_i);
			req_valid_i <= 1'b0;
			@(negedge mclk_i);
			if (rows[i].r.write) check(hwdata_o, rows[i].r.wdata);
			wait_rsp(1'b0, rows[i].d);
		end
		err_case(mk(32'h200, 1'b0, 1'b0, 1'b0), mk(32'h208, 1'b0, 1'b0, 1'b0), 1'b1);
		err_case(mk(32'h20c, 1'b1, 1'b0, 1'b0), mk(32'h210, 1'b1, 1'b0, 1'b1), 1'b0);
		err_case(mk(32'h300, 1'b0, 1'b1, 1'b0), mk(32'h308, 1'b0, 1'b1, 1'b1), 1'b0);
		retract(mk(32'h408, 1'b0, 1'b1, 1'b1), mk(32'h600, 1'b0, 1'b0, 1'b0));
		retract(mk(32'h700, 1'b1, 1'b0, 1'b0), mk(32'h800, 1'b0, 1'b1, 1'b0));
		// ****************************************
		// Reset in mid-run clears the registered outputs
		// ****************************************
		@(posedge mclk_i);
		resetn_i <= 1'b0;
		@(negedge mclk_i);
		check(64'(rsp_o.valid), 64'h0);
		check(hwdata_o, `RST_DATA);
		// Release again and show that an idle bus takes the next read at once
		@(posedge mclk_i);
		resetn_i <= 1'b1;
		issue(mk(32'h900, 1'b0, 1'b0, 1'b0), 4'h1, 1'b0);
		@(posedge mclk_i);
		req_valid_i <= 1'b0;
		wait_rsp(1'b0, rd(mk(32'h900, 1'b0, 1'b0, 1'b0)));
		print_verdict();
	end
endmodule
